// *** verilog/rtc_port_defs.svh ***
/*
  Constants shared by both ends of the parallel clock-chip port:
  control register placement, reset levels and host strobe timing.
  Assumes inclusion by bare name from files that need the figures.
*/
`ifndef RTC_PORT_DEFS_SVH
`define RTC_PORT_DEFS_SVH

// Register holding the clock output controls
`define CLKCTL_ADDR 4'hE
`define CLKCTL_FE_BIT 3
`define CLKCTL_FD_MSB 2
`define CLKCTL_FD_LSB 0
`define REG_RESET 4'h0

// Host strobe timing in mclk cycles
`define HOST_SETUP_CYC 4'h4
`define HOST_STROBE_CYC 4'h8
`define HOST_HOLD_CYC 4'h4
`define HOST_BOOT_CYC 4'h8

`endif

// *** verilog/rtc_port_pkg.sv ***
/*
  Types shared by the two ends of the parallel clock-chip port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtc_port_pkg;
  typedef logic [3:0] nibble_t;
  typedef enum logic [2:0] {H_BOOT, H_IDLE, H_SETUP, H_STROBE,
    H_HOLD} host_state_t;
endpackage

// *** verilog/rtc_port_if.sv ***
/*
  Pin bundle between the host end and the clock chip end.
  Assumes pull-ups on the data lines and the interrupt line, and a
  weak pull-down on the clock output when nobody drives it.
*/
`timescale 1ns/1ps
`default_nettype none
interface rtc_port_if;
  logic chip_select_n;
  logic chip_select_hi;
  logic clkout_source_sel;
  logic [3:0] reg_addr;
  logic rd_n;
  logic wr_n;
  logic [3:0] host_data;
  logic host_data_oe_n;
  logic [3:0] dev_data;
  logic dev_data_oe_n;
  logic clock_out;
  logic clock_out_oe_n;
  logic irq_out;
  logic irq_oe_n;
  wire [3:0] data_bus;
  wire clock_out_line;
  wire irq_n_line;

  // Wire levels worked out from the enables
  assign data_bus = !dev_data_oe_n ? dev_data :
    (!host_data_oe_n ? host_data : 4'hF);
  assign clock_out_line = !clock_out_oe_n ? clock_out : 1'b0;
  assign irq_n_line = !irq_oe_n ? irq_out : 1'b1;

  modport device (
    input chip_select_n, chip_select_hi, clkout_source_sel, reg_addr,
    input rd_n, wr_n, data_bus,
    output dev_data, dev_data_oe_n, clock_out, clock_out_oe_n,
    output irq_out, irq_oe_n
  );
  modport host (
    output chip_select_n, chip_select_hi, clkout_source_sel, reg_addr,
    output rd_n, wr_n, host_data, host_data_oe_n,
    input data_bus, irq_n_line
  );
endinterface
`default_nettype wire

// *** verilog/pin_sync.sv ***
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is a slowly changing level; a bus is only used
  once the strobe that qualifies it has settled.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [WIDTH-1:0] din, // Asynchronous levels
  output logic [WIDTH-1:0] dout // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** verilog/rtc_device_end.sv ***
/*
  Clock chip end of the parallel port: chip select decode, register
  read and write through the strobes, clock output gating and the
  open-drain interrupt.
  Assumes the host keeps its strobe timing, and that the timekeeping
  core supplies the base clock, the divided clock and interrupt.
*/
// What this block does
// [R1] Access only with select low and high-select high
// [R2] Primary select must go high once first
// [R3] Source pin low gives base clock, else divider
// [R4] Reduced variant treats source pin as high
// [R5] Enable bit gates divider clock output
// [R6] No clock means output released
// [R7] High-select high lets output run regardless
// [R8] High-select low forces output released
// [R9] Selected read drives addressed register contents
// [R10] Write captures data at write strobe rise
// [R11] Host never lowers both strobes together
// [R12] Host presents four-bit register address
// [R13] Interrupt only pulls low, otherwise released
// [R14] Data lines released except during reads
`timescale 1ns/1ps
`default_nettype none
`include "rtc_port_defs.svh"
module rtc_device_end
  import rtc_port_pkg::*;
#(
  parameter bit HAS_SOURCE_SEL = 1'b1, // Zero for the reduced-pin part
  parameter int NUM_REGS = 16
) (
  input wire logic mclk, // System clock, 40 MHz
  input wire logic rst, // Async reset, high
  rtc_port_if.device port, // Pins toward the host
  input wire logic base_clk, // Fixed base clock level
  input wire logic div_clk, // Divider-selected clock level
  input wire logic irq_req, // Interrupt request, same clock
  output logic [2:0] freq_divider_sel, // Divider field to the core
  output logic clkout_enable, // Enable bit to the core
  output logic wr_pulse, // One cycle per accepted write
  output logic [3:0] wr_addr, // Address of the last write
  output logic [3:0] wr_data // Data of the last write
);
  localparam int SYNC_W = 15;
  // Reset levels match idle pins so no false strobe edge follows reset;
  // the primary select reads low so arming needs a real high level
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h1C3C;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  wire cs_n_s;
  wire cs_hi_s;
  wire src_pin_s;
  wire rd_n_s;
  wire wr_n_s;
  wire [3:0] addr_s;
  wire [3:0] data_s;
  wire base_s;
  wire div_s;

  logic armed_r;
  logic wr_n_d_r;
  nibble_t regs_r [NUM_REGS];
  nibble_t rd_data_r;
  logic rd_oe_n_r;
  logic clk_val_r;
  logic clk_oe_n_r;
  logic irq_oe_n_r;
  logic wr_pulse_r;
  nibble_t wr_addr_r;
  nibble_t wr_data_r;

  // Every pin and the foreign clock levels pass two flip-flops
  assign sync_in = {port.chip_select_n, port.chip_select_hi,
    port.clkout_source_sel, port.rd_n, port.wr_n, port.reg_addr,
    port.data_bus, base_clk, div_clk};

  pin_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign {cs_n_s, cs_hi_s, src_pin_s, rd_n_s, wr_n_s, addr_s, data_s,
    base_s, div_s} = sync_out;

  // Access decode; the arm flag keeps a select that started low out
  wire selected = armed_r && !cs_n_s && cs_hi_s; // [R1] [R2]
  wire strobe_clash = !rd_n_s && !wr_n_s; // [R11]
  wire read_on = selected && !rd_n_s && !strobe_clash; // [R9] [R14]
  wire wr_rise = selected && wr_n_s && !wr_n_d_r; // [R10]
  wire [3:0] rd_word = regs_r[addr_s]; // [R12]

  // Clock output source and gating
  wire src_high = HAS_SOURCE_SEL ? src_pin_s : 1'b1; // [R4]
  nibble_t ctl_word;
  assign ctl_word = regs_r[`CLKCTL_ADDR];
  wire fe_bit = ctl_word[`CLKCTL_FE_BIT];
  wire clk_active = cs_hi_s && (!src_high || fe_bit); // [R5] [R7] [R8]
  wire clk_level = src_high ? div_s : base_s; // [R3]

  assign freq_divider_sel = ctl_word[`CLKCTL_FD_MSB:`CLKCTL_FD_LSB];
  assign clkout_enable = fe_bit;

  // Arm once the primary select has been seen high after reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      armed_r <= 1'b0;
    else if (cs_n_s)
      armed_r <= 1'b1; // [R2]
  end

  // Previous write strobe level for the rising edge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wr_n_d_r <= 1'b1;
    else
      wr_n_d_r <= wr_n_s;
  end

  // Register array, one writable nibble per address
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          regs_r[gi] <= `REG_RESET;
        else if (wr_rise && (addr_s == 4'(gi)))
          regs_r[gi] <= data_s; // [R10]
      end
    end
  endgenerate

  // Write report toward the core, data held until the next write
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_pulse_r <= 1'b0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 4'h0;
    end
    else
    begin
      wr_pulse_r <= wr_rise;
      if (wr_rise)
      begin
        wr_addr_r <= addr_s;
        wr_data_r <= data_s;
      end
    end
  end

  assign wr_pulse = wr_pulse_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;

  // Read drive; lines stay released outside a clean read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_r <= 4'h0;
      rd_oe_n_r <= 1'b1;
    end
    else
    begin
      rd_data_r <= rd_word; // [R9]
      rd_oe_n_r <= !read_on; // [R14]
    end
  end

  assign port.dev_data = rd_data_r;
  assign port.dev_data_oe_n = rd_oe_n_r;

  // Clock output; released whenever it has nothing to carry
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clk_val_r <= 1'b0;
      clk_oe_n_r <= 1'b1;
    end
    else
    begin
      clk_val_r <= clk_active ? clk_level : 1'b0;
      clk_oe_n_r <= !clk_active; // [R6] [R8]
    end
  end

  assign port.clock_out = clk_val_r;
  assign port.clock_out_oe_n = clk_oe_n_r;

  // Open-drain interrupt: only ever pulls the line low
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_oe_n_r <= 1'b1;
    else
      irq_oe_n_r <= !irq_req; // [R13]
  end

  assign port.irq_out = 1'b0; // [R13]
  assign port.irq_oe_n = irq_oe_n_r;
endmodule
`default_nettype wire

// *** verilog/rtc_host_end.sv ***
/*
  Host end of the parallel clock-chip port: turns one user request
  into a strobe cycle with setup and hold around it.
  Assumes the device answers within the strobe length and that the
  user waits for ack before the next request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtc_port_defs.svh"
module rtc_host_end
  import rtc_port_pkg::*;
(
  input wire logic mclk, // System clock, 40 MHz
  input wire logic rst, // Async reset, high
  rtc_port_if.host port, // Pins toward the device
  input wire logic req, // Request pulse or level
  input wire logic req_write, // One for write, zero for read
  input wire logic [3:0] req_addr, // Register address
  input wire logic [3:0] req_wdata, // Write data
  input wire logic clk_run, // Keep high-select up for clock output
  input wire logic src_sel, // Clock output source pin level
  output logic busy, // Boot or access in progress
  output logic ack, // One cycle at the end of an access
  output logic [3:0] rdata, // Read result, held
  output logic irq_seen // Interrupt line low, synchronised
);
  host_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic write_r;
  nibble_t addr_r, wdata_r, rdata_r;
  logic [4:0] rx_s;

  pin_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h1F)
  ) u_rx_sync (
    .mclk(mclk),
    .rst(rst),
    .din({port.data_bus, port.irq_n_line}),
    .dout(rx_s)
  );

  wire in_access = (state_r == H_SETUP) || (state_r == H_STROBE) ||
    (state_r == H_HOLD);
  wire strobe_on = (state_r == H_STROBE);
  wire strobe_end = strobe_on && (cnt_r == 4'h1);

  // Sequencer; boot holds the primary select high before any access
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
    unique case (state_r)
      H_BOOT:
        if (cnt_r == 4'h0)
          state_nxt = H_IDLE; // [R2]
      H_IDLE:
        if (req)
        begin
          state_nxt = H_SETUP;
          cnt_nxt = `HOST_SETUP_CYC;
        end
      H_SETUP:
        if (cnt_r == 4'h1)
        begin
          state_nxt = H_STROBE;
          cnt_nxt = `HOST_STROBE_CYC;
        end
      H_STROBE:
        if (cnt_r == 4'h1)
        begin
          state_nxt = H_HOLD;
          cnt_nxt = `HOST_HOLD_CYC;
        end
      H_HOLD:
        if (cnt_r == 4'h1)
          state_nxt = H_IDLE;
    endcase
  end

  // State and counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= H_BOOT;
      cnt_r <= `HOST_BOOT_CYC;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Request capture and read sampling at the end of the strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      write_r <= 1'b0;
      addr_r <= 4'h0;
      wdata_r <= 4'h0;
      rdata_r <= 4'h0;
    end
    else
    begin
      if (state_r == H_IDLE && req)
      begin
        write_r <= req_write;
        addr_r <= req_addr; // [R12]
        wdata_r <= req_wdata;
      end
      if (strobe_end && !write_r)
        rdata_r <= rx_s[4:1];
    end
  end

  // Pins: one strobe at a time, data driven only for writes
  assign port.chip_select_n = !in_access; // [R1] [R2]
  assign port.chip_select_hi = in_access || clk_run; // [R1]
  assign port.clkout_source_sel = src_sel;
  assign port.reg_addr = addr_r;
  assign port.rd_n = !(strobe_on && !write_r); // [R11]
  assign port.wr_n = !(strobe_on && write_r); // [R11]
  assign port.host_data = wdata_r;
  assign port.host_data_oe_n = !(in_access && write_r);

  assign busy = (state_r != H_IDLE);
  assign ack = (state_r == H_HOLD) && (cnt_r == 4'h1);
  assign rdata = rdata_r;
  assign irq_seen = !rx_s[0];
endmodule
`default_nettype wire

// *** tb/rtc_port_properties.sv ***
/*
  Timing properties on the pins between host end and clock chip end.
  Assumes instantiation beside the interface, all signals on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_port_properties (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic chip_select_n, // Primary select, low
  input wire logic chip_select_hi, // Secondary select
  input wire logic clkout_source_sel, // Output source pin
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic dev_data_oe_n, // Device data enable, low
  input wire logic clock_out_oe_n, // Clock out enable, low
  input wire logic irq_out, // Interrupt drive level
  input wire logic irq_oe_n // Interrupt enable, low
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Five cycles cover the two-flop sync plus the output register
  sequence s_sel_read;
    (!chip_select_n && chip_select_hi && !rd_n && wr_n)[*5];
  endsequence
  sequence s_no_read;
    rd_n[*5];
  endsequence
  sequence s_unsel;
    (chip_select_n || !chip_select_hi)[*5];
  endsequence
  sequence s_hi_low;
    (!chip_select_hi)[*5];
  endsequence
  sequence s_base;
    (chip_select_hi && !clkout_source_sel)[*5];
  endsequence

  property p_read_drive;
    s_sel_read |-> !dev_data_oe_n;
  endproperty
  property p_no_stray_drive;
    s_no_read |-> dev_data_oe_n;
  endproperty
  property p_unsel_quiet;
    s_unsel |-> dev_data_oe_n;
  endproperty
  property p_clk_forced_off;
    s_hi_low |-> clock_out_oe_n;
  endproperty
  property p_base_clock;
    s_base |-> !clock_out_oe_n;
  endproperty
  property p_boot_select;
    $fell(rst) |-> chip_select_n[*8];
  endproperty
  property p_irq_open_drain;
    !irq_oe_n |-> !irq_out;
  endproperty
  property p_strobe_excl;
    rd_n || wr_n;
  endproperty

  a_read_drive: assert property (p_read_drive)
    else $error("selected read not driven");
  a_no_stray_drive: assert property (p_no_stray_drive)
    else $error("data driven without read");
  a_unsel_quiet: assert property (p_unsel_quiet)
    else $error("data driven while unselected");
  a_clk_forced_off: assert property (p_clk_forced_off)
    else $error("clock out driven with high select low");
  a_base_clock: assert property (p_base_clock)
    else $error("base clock not driven");
  a_boot_select: assert property (p_boot_select)
    else $error("primary select low during boot");
  a_irq_open_drain: assert property (p_irq_open_drain)
    else $error("interrupt line driven high");
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("both strobes low");
endmodule
`default_nettype wire

// *** tb/tb_rtc_parallel_port_clkout_gate.sv ***
/*
  Self-checking bench joining the host end to the clock chip end.
  Assumes both ends meet in rtc_port_if; the checker sits beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_parallel_port_clkout_gate;
  import rtc_port_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  nibble_t req_addr = 4'h0;
  nibble_t req_wdata = 4'h0;
  logic clk_run = 1'b0;
  logic src_sel = 1'b1;
  logic base_clk = 1'b1;
  logic div_clk = 1'b0;
  logic irq_req = 1'b0;
  logic busy, ack, irq_seen, clkout_enable, wr_pulse;
  nibble_t rdata, wr_addr, wr_data;
  logic [2:0] freq_divider_sel;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int wr_pulses = 0;

  rtc_port_if bus ();
  rtc_host_end rtc_host_end_inst (.mclk(mclk), .rst(rst), .port(bus),
    .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .clk_run(clk_run), .src_sel(src_sel),
    .busy(busy), .ack(ack), .rdata(rdata), .irq_seen(irq_seen));
  rtc_device_end rtc_device_end_inst (.mclk(mclk), .rst(rst),
    .port(bus), .base_clk(base_clk), .div_clk(div_clk),
    .irq_req(irq_req), .freq_divider_sel(freq_divider_sel),
    .clkout_enable(clkout_enable), .wr_pulse(wr_pulse),
    .wr_addr(wr_addr), .wr_data(wr_data));
  rtc_port_properties rtc_port_properties_inst (.mclk(mclk), .rst(rst),
    .chip_select_n(bus.chip_select_n), .chip_select_hi(bus.chip_select_hi),
    .clkout_source_sel(bus.clkout_source_sel), .rd_n(bus.rd_n),
    .wr_n(bus.wr_n), .dev_data_oe_n(bus.dev_data_oe_n),
    .clock_out_oe_n(bus.clock_out_oe_n), .irq_out(bus.irq_out),
    .irq_oe_n(bus.irq_oe_n));

  always #12.5 mclk = ~mclk;

  // Count write reports; each accepted write must give exactly one
  always @(posedge mclk)
  begin
    if (wr_pulse === 1'b1)
      wr_pulses <= wr_pulses + 1;
  end

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [3:0] seen,
    input logic [3:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request pulse while idle, then a bounded wait for ack
  task automatic access(input logic w, input nibble_t a, input nibble_t d);
    int n;
    @(posedge mclk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge mclk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100)
      num_errors++;
    repeat (2) @(posedge mclk);
  endtask

  // Register round trips, including the clock control register
  task automatic t_write_read();
    check("idle bus", bus.data_bus, 4'hF);
    access(1'b1, 4'h3, 4'hA);
    check("wr_addr", wr_addr, 4'h3);
    check("wr_data", wr_data, 4'hA);
    access(1'b0, 4'h3, 4'h0);
    check("rdata", rdata, 4'hA);
    access(1'b1, 4'hE, 4'hD);
    check("divider", {1'b0, freq_divider_sel}, 4'h5);
    check("enable", {3'h0, clkout_enable}, 4'h1);
    access(1'b0, 4'hE, 4'h0);
    check("rdata ctl", rdata, 4'hD);
    check("write pulses", 4'(wr_pulses), 4'h2);
  endtask

  // Each row: run, source, enable, expected oe_n and line level
  task automatic t_gate();
    logic [4:0] tbl [4];
    tbl = '{5'b00110, 5'b10001, 5'b11010, 5'b11100};
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, 4'hE, {tbl[i][2], 3'h2});
      clk_run <= tbl[i][4];
      src_sel <= tbl[i][3];
      repeat (8) @(posedge mclk);
      check("clock out", {2'h0, bus.clock_out_oe_n, bus.clock_out_line},
        {2'h0, tbl[i][1:0]});
      // Swap the source levels so the line must follow the chosen clock
      base_clk <= 1'b0;
      div_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      check("clock level", {2'h0, bus.clock_out_oe_n, bus.clock_out_line},
        {2'h0, tbl[i][1], !tbl[i][1] && !tbl[i][0]});
      base_clk <= 1'b1;
      div_clk <= 1'b0;
    end
  endtask

  // Interrupt only pulls the line low
  task automatic t_irq();
    irq_req <= 1'b1;
    repeat (6) @(posedge mclk);
    check("irq low", {2'h0, irq_seen, bus.irq_n_line}, 4'h2);
    irq_req <= 1'b0;
    repeat (6) @(posedge mclk);
    check("irq free", {2'h0, irq_seen, bus.irq_n_line}, 4'h1);
  endtask

  // Cut a hang short well past the expected run length
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("boot select", {3'h0, bus.chip_select_n}, 4'h1);
    check("boot busy", {3'h0, busy}, 4'h1);
    repeat (11) @(posedge mclk);
    t_write_read();
    t_gate();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
